//--- core/aarc_top.sv
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - Input four divider: off, /1, /2, /4; reset 11.
// - Input four reference: backup domain or main; reset 1.
// - Input four result twelve bits, resets zero.
// - USB supply result read-only, low twelve bits.
// - Adaptor supply result read-only, low twelve bits.
// - Battery result read-only in own register.
// - Die temperature result read-only in own register.
// - Four comparator enables, bit three down to zero.
// - State machine reset clears enables and sources.
// - Three-bit source picks one of eight measurements.
// - Direction bit: below when 0, above when 1.
// - Twelve-bit unsigned threshold compared with measurement.
// - Hold blocks conversions until pending result read.
module aarc_top (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [aarc_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [aarc_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [aarc_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [aarc_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire aarc_pkg::aarc_conv_s           conv_result,
  input  wire logic                           sm_reset,
  output logic                                conv_hold,
  output logic [1:0]                          input4_divider_select,
  output logic                                input4_reference_select,
  output logic [aarc_pkg::NUM_CMP-1:0]        comparator_flags
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  aarc_pkg::aarc_wr_e                 wr_state_q;
  aarc_pkg::aarc_rd_e                 rd_state_q;
  logic                               aw_held_q;
  logic                               w_held_q;
  logic [aarc_pkg::ADDR_W-1:0]        awaddr_q;
  logic [aarc_pkg::DATA_W-1:0]        wdata_q;
  logic [3:0]                         wstrb_q;
  logic [1:0]                         bresp_q;
  logic [aarc_pkg::DATA_W-1:0]        rdata_q;
  logic [1:0]                         rresp_q;
  logic [1:0]                         div_q;
  logic                               ref_q;
  logic                               hold_q;
  logic                               pending_q;
  logic [aarc_pkg::NUM_CMP-1:0]       en_q;
  logic [aarc_pkg::NUM_CMP-1:0]       flag_q;
  logic [aarc_pkg::RES_W-1:0]         res_q [aarc_pkg::NUM_SRC];
  aarc_pkg::aarc_cmp_s                setup_q [aarc_pkg::NUM_CMP];
  logic [aarc_pkg::NUM_CMP-1:0]       cmp_set;
  logic [aarc_pkg::REG_W-1:0]         rd_val;
  logic                               rd_ok;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------------------
  wire                          wr_idle   = (wr_state_q == aarc_pkg::WR_COLLECT);
  wire                          wr_commit = wr_idle && aw_held_q && w_held_q;
  wire [aarc_pkg::IDX_W-1:0]    wr_idx    = awaddr_q[aarc_pkg::ADDR_W-1:2];
  wire [15:0]                   wr_data   = wdata_q[15:0];
  wire [1:0]                    wr_strb   = wstrb_q[1:0];
  wire                          hit_aux4  = wr_commit && (wr_idx == aarc_pkg::IDX_AUX4);
  wire                          hit_hold  = wr_commit && (wr_idx == aarc_pkg::IDX_HOLD_CTRL);
  wire                          hit_flags = wr_commit && (wr_idx == aarc_pkg::IDX_CMP_FLAGS);
  wire                          hit_en    = wr_commit && (wr_idx == aarc_pkg::IDX_CMP_EN);
  wire                          wr_setup_rng = (wr_idx[9:2] == aarc_pkg::IDX_CMP_SETUP[9:2]);
  wire                          wr_ro_rng = (wr_idx >= aarc_pkg::IDX_USB)
                                         && (wr_idx <= aarc_pkg::IDX_TEMP);
  wire                          wr_mapped = (wr_idx == aarc_pkg::IDX_AUX4) || wr_ro_rng
                                         || (wr_idx == aarc_pkg::IDX_HOLD_CTRL)
                                         || (wr_idx == aarc_pkg::IDX_CMP_FLAGS)
                                         || (wr_idx == aarc_pkg::IDX_CMP_EN) || wr_setup_rng;
  wire [15:0]                   aux4_ctl  = {1'b0, div_q, ref_q, aarc_pkg::RES_RST};
  wire [15:0]                   aux4_new  = merge16(aux4_ctl, wr_data, wr_strb);
  wire [aarc_pkg::NUM_CMP-1:0]  flag_clr  = (hit_flags && wr_strb[0])
                                         ? wr_data[aarc_pkg::NUM_CMP-1:0] : aarc_pkg::EN_RST;

  assign s_axi_awready = wr_idle && !aw_held_q;
  assign s_axi_wready  = wr_idle && !w_held_q;
  assign s_axi_bvalid  = (wr_state_q == aarc_pkg::WR_RESP);
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= aarc_pkg::WR_COLLECT;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      awaddr_q   <= '0;
      wdata_q    <= '0;
      wstrb_q    <= '0;
      bresp_q    <= aarc_pkg::RESP_OKAY;
    end else begin
      case (wr_state_q)
        aarc_pkg::WR_COLLECT: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
          end
          if (wr_commit) begin
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            bresp_q    <= wr_mapped ? aarc_pkg::RESP_OKAY : aarc_pkg::RESP_SLVERR;
            wr_state_q <= aarc_pkg::WR_RESP;
          end
        end
        default: begin
          if (s_axi_bready) begin
            wr_state_q <= aarc_pkg::WR_COLLECT;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------------
  wire                       rd_take = s_axi_arvalid && s_axi_arready;
  wire [aarc_pkg::IDX_W-1:0] rd_idx  = s_axi_araddr[aarc_pkg::ADDR_W-1:2];
  wire                       rd_aux4 = rd_take && (rd_idx == aarc_pkg::IDX_AUX4);
  wire                       rd_setup_rng = (rd_idx[9:2] == aarc_pkg::IDX_CMP_SETUP[9:2]);

  assign s_axi_arready = (rd_state_q == aarc_pkg::RD_IDLE);
  assign s_axi_rvalid  = (rd_state_q == aarc_pkg::RD_RESP);
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    if (rd_idx == aarc_pkg::IDX_AUX4) begin
      rd_val = {1'b0, div_q, ref_q, res_q[aarc_pkg::SRC_AUX4]};
    end else if (rd_idx == aarc_pkg::IDX_USB) begin
      rd_val = {4'h0, res_q[aarc_pkg::SRC_USB]};
    end else if (rd_idx == aarc_pkg::IDX_LINE) begin
      rd_val = {4'h0, res_q[aarc_pkg::SRC_LINE]};
    end else if (rd_idx == aarc_pkg::IDX_BATT) begin
      rd_val = {4'h0, res_q[aarc_pkg::SRC_BATT]};
    end else if (rd_idx == aarc_pkg::IDX_TEMP) begin
      rd_val = {4'h0, res_q[aarc_pkg::SRC_TEMP]};
    end else if (rd_idx == aarc_pkg::IDX_HOLD_CTRL) begin
      rd_val = {14'h0000, pending_q, hold_q};
    end else if (rd_idx == aarc_pkg::IDX_CMP_FLAGS) begin
      rd_val = {12'h000, flag_q};
    end else if (rd_idx == aarc_pkg::IDX_CMP_EN) begin
      rd_val = {12'h000, en_q};
    end else if (rd_setup_rng) begin
      rd_val = setup_q[rd_idx[1:0]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= aarc_pkg::RD_IDLE;
      rdata_q    <= '0;
      rresp_q    <= aarc_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rdata_q    <= {16'h0000, rd_val};
      rresp_q    <= rd_ok ? aarc_pkg::RESP_OKAY : aarc_pkg::RESP_SLVERR;
      rd_state_q <= aarc_pkg::RD_RESP;
    end else if (s_axi_rvalid && s_axi_rready) begin
      rd_state_q <= aarc_pkg::RD_IDLE;
    end
  end

  // ---------------------------------------------------------------------------
  // Input four control, hold and results
  // ---------------------------------------------------------------------------
  // A result offered while the hold is closed is dropped, not queued; the
  // converter is expected to wait on conv_hold.
  assign conv_hold = hold_q && pending_q;
  wire   store     = conv_result.valid && !conv_hold;
  wire   aux_store = store && (conv_result.source <= aarc_pkg::SRC_AUX4);
  wire   pending_d = (pending_q && !rd_aux4) || (hold_q && aux_store);

  assign input4_divider_select   = div_q;
  assign input4_reference_select = ref_q;
  assign comparator_flags        = flag_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q     <= aarc_pkg::DIV_RST;
      ref_q     <= aarc_pkg::REF_RST;
      hold_q    <= 1'b0;
      pending_q <= 1'b0;
      en_q      <= aarc_pkg::EN_RST;
      flag_q    <= aarc_pkg::EN_RST;
    end else begin
      if (hit_aux4) begin
        div_q <= aux4_new[aarc_pkg::DIV_HI:aarc_pkg::DIV_LO];
        ref_q <= aux4_new[aarc_pkg::REF_BIT];
      end
      if (sm_reset) begin
        hold_q <= 1'b0;
        en_q   <= aarc_pkg::EN_RST;
      end else begin
        if (hit_hold && wr_strb[0]) begin
          hold_q <= wr_data[aarc_pkg::HOLD_BIT];
        end
        if (hit_en && wr_strb[0]) begin
          en_q <= wr_data[aarc_pkg::NUM_CMP-1:0];
        end
      end
      pending_q <= pending_d;
      flag_q    <= (flag_q & ~flag_clr) | cmp_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < aarc_pkg::NUM_SRC; s++) begin
        res_q[s] <= aarc_pkg::RES_RST;
      end
    end else if (store) begin
      res_q[conv_result.source] <= conv_result.data;
    end
  end

  // ---------------------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------------------
  for (genvar i = 0; i < aarc_pkg::NUM_CMP; i++) begin : g_cmp
    wire        wr_this = wr_commit && wr_setup_rng && (wr_idx[1:0] == 2'(i));
    wire [15:0] new_val = merge16(setup_q[i], wr_data, wr_strb);
    wire        src_hit = store && en_q[i] && (conv_result.source == setup_q[i].source);
    wire        above   = conv_result.data > setup_q[i].thr;
    wire        below   = conv_result.data < setup_q[i].thr;

    assign cmp_set[i] = src_hit && (setup_q[i].dir ? above : below);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        setup_q[i] <= aarc_pkg::SETUP_RST;
      end else if (sm_reset) begin
        setup_q[i].source <= aarc_pkg::SRC_RST;
      end else if (wr_this) begin
        setup_q[i] <= new_val;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // Comparator zero stands for all four; they share one generated structure.
  a_div_reset: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (input4_divider_select == aarc_pkg::DIV_RST))
    else $error("divider select not at reset value");

  a_ref_reset: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> input4_reference_select && (res_q[aarc_pkg::SRC_AUX4] == '0))
    else $error("reference select or result not at reset value");

  a_aux4_store: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (store && (conv_result.source == aarc_pkg::SRC_AUX4)) |=>
    (res_q[aarc_pkg::SRC_AUX4] == $past(conv_result.data)))
    else $error("input four result not stored");

  a_usb_read: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (rd_take && (rd_idx == aarc_pkg::IDX_USB)) |=>
    s_axi_rvalid && (s_axi_rdata == {20'h00000, $past(res_q[aarc_pkg::SRC_USB])}))
    else $error("usb result readback wrong");

  a_line_store: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (store && (conv_result.source == aarc_pkg::SRC_LINE)) ##1
    !(store && (conv_result.source == aarc_pkg::SRC_LINE)) |=>
    (res_q[aarc_pkg::SRC_LINE] == $past(conv_result.data, 2)))
    else $error("adaptor result not held");

  a_batt_keep: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(store && (conv_result.source == aarc_pkg::SRC_BATT)) |=> $stable(res_q[aarc_pkg::SRC_BATT]))
    else $error("battery result changed without a store");

  a_temp_ro: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_commit && !(store && (conv_result.source == aarc_pkg::SRC_TEMP))
    |=> $stable(res_q[aarc_pkg::SRC_TEMP]))
    else $error("temperature result changed by a write");

  a_enable_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(flag_q[0]) |-> $past(en_q[0]))
    else $error("disabled comparator raised a flag");

  a_sm_reset: assert property (
    @(posedge aclk) disable iff (!aresetn)
    sm_reset |=> (en_q == '0) && (setup_q[0].source == '0) && (setup_q[3].source == '0))
    else $error("state machine reset left enables or sources set");

  a_above_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (store && en_q[0] && (conv_result.source == setup_q[0].source) && setup_q[0].dir
     && (conv_result.data > setup_q[0].thr)) |=> flag_q[0])
    else $error("above-threshold condition missed");

  a_below_flag: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (store && en_q[0] && (conv_result.source == setup_q[0].source) && !setup_q[0].dir
     && (conv_result.data < setup_q[0].thr)) |=> flag_q[0])
    else $error("below-threshold condition missed");

  // A result equal to the threshold must never raise the flag, in either direction.
  a_equal_quiet: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (store && (conv_result.data == setup_q[0].thr) && !flag_q[0]) |=> !flag_q[0])
    else $error("comparator flagged on a result equal to its threshold");

  a_hold_block: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (hold_q && aux_store && !sm_reset && !hit_hold) |=> conv_hold)
    else $error("hold did not close after a pending result");

  a_hold_keep: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (conv_hold && !rd_aux4 && !sm_reset && !hit_hold) |=> conv_hold)
    else $error("hold opened before the pending result was read");

  a_flag_sticky: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (flag_q[0] && !flag_clr[0]) |=> flag_q[0])
    else $error("comparator flag lost without a clear");

  a_bresp_after: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (hit_en && wr_strb[0] && !sm_reset) |=> s_axi_bvalid && (en_q == $past(wr_data[3:0])))
    else $error("enable write not applied before response");

endmodule

//--- core/aarc_pkg.sv
package aarc_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned IDX_W   = 10;
  localparam int unsigned RES_W   = 12;
  localparam int unsigned REG_W   = 16;
  localparam int unsigned NUM_SRC = 8;
  localparam int unsigned NUM_CMP = 4;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_AUX4      = 10'h09B;
  localparam logic [IDX_W-1:0] IDX_USB       = 10'h09C;
  localparam logic [IDX_W-1:0] IDX_LINE      = 10'h09D;
  localparam logic [IDX_W-1:0] IDX_BATT      = 10'h09E;
  localparam logic [IDX_W-1:0] IDX_TEMP      = 10'h09F;
  localparam logic [IDX_W-1:0] IDX_HOLD_CTRL = 10'h0A0;
  localparam logic [IDX_W-1:0] IDX_CMP_FLAGS = 10'h0A1;
  localparam logic [IDX_W-1:0] IDX_CMP_EN    = 10'h0A3;
  localparam logic [IDX_W-1:0] IDX_CMP_SETUP = 10'h0A4;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned DIV_HI   = 14;
  localparam int unsigned DIV_LO   = 13;
  localparam int unsigned REF_BIT  = 12;
  localparam int unsigned HOLD_BIT = 0;

  localparam logic [1:0]         DIV_RST  = 2'h3;
  localparam logic               REF_RST  = 1'b1;
  localparam logic [2:0]         SRC_RST  = 3'h0;
  localparam logic [RES_W-1:0]   RES_RST  = 12'h000;
  localparam logic [NUM_CMP-1:0] EN_RST   = 4'h0;
  localparam logic [REG_W-1:0]   SETUP_RST = 16'h0000;

  // Source codes of the converter result path.
  localparam logic [2:0] SRC_AUX4 = 3'h3;
  localparam logic [2:0] SRC_USB  = 3'h4;
  localparam logic [2:0] SRC_LINE = 3'h5;
  localparam logic [2:0] SRC_BATT = 3'h6;
  localparam logic [2:0] SRC_TEMP = 3'h7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic             valid;
    logic [2:0]       source;
    logic [RES_W-1:0] data;
  } aarc_conv_s;

  typedef struct packed {
    logic [2:0]       source;
    logic             dir;
    logic [RES_W-1:0] thr;
  } aarc_cmp_s;

  typedef enum logic {WR_COLLECT, WR_RESP} aarc_wr_e;
  typedef enum logic {RD_IDLE, RD_RESP}    aarc_rd_e;

endpackage

//--- verif/aarc_conv_model.sv
`timescale 1ns/1ps
// Stand-in for the converter result path: one result per call of send.
module aarc_conv_model (
  input  wire logic            aclk,
  input  wire logic            conv_hold,
  output aarc_pkg::aarc_conv_s conv_result
);
  initial conv_result = '0;
  // ---------------------------------------------------------------------------
  // Delivery
  // ---------------------------------------------------------------------------
  task automatic send(input logic [2:0] src, input logic [11:0] d, input logic obey,
                      input int gap);
    repeat (gap + 1) @(posedge aclk);
    while (obey && conv_hold) @(posedge aclk);
    conv_result <= {1'b1, src, d};
    @(posedge aclk);
    // The payload is inverted between results so a stale value never looks fresh.
    conv_result <= {1'b0, ~src, ~d};
  endtask
endmodule

//--- verif/test_aux_adc_readback_comparators.sv
`timescale 1ns/1ps
module test_aux_adc_readback_comparators;
  logic                 aclk = 1'b0;
  logic                 aresetn = 1'b0;
  logic                 sm_reset = 1'b0;
  logic [11:0]          awaddr = '0, araddr = '0;
  logic [31:0]          wdata = '0, rdata, rnd = 32'hCC9F51C7;
  logic [3:0]           wstrb = '0, flags;
  logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                 arvalid = 1'b0, rready = 1'b0;
  logic                 awready, wready, bvalid, arready, rvalid, conv_hold, ref_sel;
  logic [1:0]           bresp, rresp, div_sel;
  aarc_pkg::aarc_conv_s conv;
  int                   fails = 0, n_checks = 0, cyc = 0;

  always #4 aclk = ~aclk;

  aarc_top i_aarc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .conv_result(conv), .sm_reset(sm_reset), .conv_hold(conv_hold),
    .input4_divider_select(div_sel), .input4_reference_select(ref_sel),
    .comparator_flags(flags));

  aarc_conv_model i_aarc_conv_model (.aclk(aclk), .conv_hold(conv_hold), .conv_result(conv));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic nxt();
    rnd = lfsr(rnd);
  endtask

  function automatic logic flag_exp(logic en, logic [2:0] cs, logic dir, logic [11:0] thr,
                                    logic [2:0] s, logic [11:0] d);
    return en && (cs == s) && (dir ? (d > thr) : (d < thr));
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // Cuts a hang short; the ceiling is over twenty times the expected run length.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      test_done();
    end
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    int          k, c;
    logic [11:0] thr[4];
    logic [2:0]  cs[4];
    logic        cd[4];
    logic [3:0]  en, ef;
    logic [2:0]  s;
    logic [11:0] d, v1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(aarc_pkg::IDX_AUX4, 32'h7000, aarc_pkg::RESP_OKAY);
    for (k = 0; k < 4; k++) rd(aarc_pkg::IDX_USB + 10'(k), 32'h0, 2'h0);
    rd(aarc_pkg::IDX_CMP_EN, 32'h0, aarc_pkg::RESP_OKAY);
    rd(aarc_pkg::IDX_CMP_SETUP, 32'h0, aarc_pkg::RESP_OKAY);
    for (k = 0; k < 8; k++) begin
      nxt();
      wr(aarc_pkg::IDX_AUX4, {rnd[31:15], k[2:1], k[0], rnd[11:0]}, 2'h0);
      rd(aarc_pkg::IDX_AUX4, {17'h0, k[2:1], k[0], 12'h000}, 2'h0);
      chk("div_pins", {29'h0, k[2:0]}, {29'h0, div_sel, ref_sel});
    end
    for (k = 3; k < 8; k++) begin
      nxt();
      i_aarc_conv_model.send(k[2:0], rnd[11:0], 1'b1, k - 3);
      if (k > 3) wr(aarc_pkg::IDX_AUX4 + 10'(k - 3), ~rnd, 2'h0);
      rd(aarc_pkg::IDX_AUX4 + 10'(k - 3), {20'h0, rnd[11:0]} | (k == 3 ? 32'h7000 : 32'h0),
         2'h0);
    end
    rd(10'h100, 32'h0, aarc_pkg::RESP_SLVERR);
    wr(10'h100, 32'hFFFF, aarc_pkg::RESP_SLVERR);
    for (k = 0; k < 24; k++) begin
      for (c = 0; c < 4; c++) begin
        nxt();
        cs[c] = rnd[15:13];
        cd[c] = rnd[12];
        thr[c] = rnd[11:0];
        wr(aarc_pkg::IDX_CMP_SETUP + 10'(c), {16'h0, rnd[15:0]}, 2'h0);
      end
      nxt();
      en = rnd[3:0];
      s = cs[rnd[5:4]];
      d = thr[rnd[5:4]] + 12'(rnd[7:6]) - 12'h001;
      wr(aarc_pkg::IDX_CMP_EN, {28'h0, en}, 2'h0);
      wr(aarc_pkg::IDX_CMP_FLAGS, 32'hF, 2'h0);
      i_aarc_conv_model.send(s, d, 1'b1, int'(rnd[9:8]));
      @(posedge aclk);
      for (c = 0; c < 4; c++) ef[c] = flag_exp(en[c], cs[c], cd[c], thr[c], s, d);
      chk("flags", {28'h0, ef}, {28'h0, flags});
    end
    rd(aarc_pkg::IDX_CMP_SETUP + 10'h3, {16'h0, cs[3], cd[3], thr[3]}, 2'h0);
    wr(aarc_pkg::IDX_HOLD_CTRL, 32'h1, 2'h0);
    nxt();
    v1 = rnd[11:0];
    i_aarc_conv_model.send(aarc_pkg::SRC_AUX4, v1, 1'b1, 0);
    @(posedge aclk);
    chk("hold", 32'h1, {31'h0, conv_hold});
    i_aarc_conv_model.send(aarc_pkg::SRC_AUX4, ~v1, 1'b0, 1);
    rd(aarc_pkg::IDX_AUX4, 32'h7000 | {20'h0, v1}, 2'h0);
    @(posedge aclk);
    chk("hold", 32'h0, {31'h0, conv_hold});
    wr(aarc_pkg::IDX_CMP_EN, 32'hF, 2'h0);
    @(posedge aclk);
    sm_reset <= 1'b1;
    @(posedge aclk);
    sm_reset <= 1'b0;
    rd(aarc_pkg::IDX_CMP_EN, 32'h0, 2'h0);
    rd(aarc_pkg::IDX_CMP_SETUP + 10'h3, {16'h0, 3'h0, cd[3], thr[3]}, 2'h0);
    rd(aarc_pkg::IDX_HOLD_CTRL, 32'h0, 2'h0);
    test_done();
  end
endmodule
